// ---- pkg/serial_host_pkg.sv ----
/*
  Shared constants, encodings and the control record of the serial host port.
  Assumes a 10 MHz core clock; all timing counts are derived from it here.
*/
package serial_host_pkg;

  // Core clock and derived link timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS   = 400;   // Shortest SPI master half period
  localparam int SCL_QTR_NS    = 2500;  // I2C master quarter bit time
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_QTR_CYC   = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 4;
  localparam int TMR_W  = 5;
  localparam int EDGE_W = 5;
  localparam int PIN_N  = 4;

  // Counter reloads and limits
  localparam logic [TMR_W-1:0]  SCK_HALF_RLD = TMR_W'(SCK_HALF_CYC - 1);
  localparam logic [TMR_W-1:0]  SCL_QTR_RLD  = TMR_W'(SCL_QTR_CYC - 1);
  localparam logic [EDGE_W-1:0] SPI_EDGES    = 5'h10;
  localparam logic [CNT_W-1:0]  LAST_BIT     = 4'h7;
  localparam logic [CNT_W-1:0]  BYTE_CNT     = 4'h8;

  // Synchroniser bit positions
  localparam int PIN_SCK  = 0;
  localparam int PIN_DAT  = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_SS   = 3;

  // Upper bits of the own I2C address; value arbitrary
  localparam logic [3:0] SLV_ADDR_TOP = 4'h5;

  // Quarter phases of one I2C bit
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;
  localparam logic [1:0] PH_3 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_SPI       = 3'b001,
    ST_I2C_START = 3'b010,
    ST_I2C_BIT   = 3'b011,
    ST_I2C_ACK   = 3'b100,
    ST_I2C_STOP  = 3'b101,
    ST_I2C_SLV   = 3'b110
  } state_e;

  typedef struct packed {
    state_e              st;
    logic [1:0]          ph;
    logic [TMR_W-1:0]    tmr;
    logic [EDGE_W-1:0]   edges;
    logic                i2c;
    logic                master;
    logic                cpol;
    logic                cpha;
    logic                busy_bus;
    logic                first;
    logic                match;
    logic                slv_ack;
    logic                sck_o;
    logic                sck_oe_n;
    logic                dat_o;
    logic                dat_oe_n;
    logic                mosi_o;
    logic                mosi_oe_n;
    logic [BYTE_W-1:0]   rx;
    logic                rx_valid;
    logic                busy;
    logic                bus_err;
    logic                start_det;
    logic                stop_det;
    logic                ack_err;
    logic                req_n;
  } ctl_s;

  // All pins released, host request idle
  localparam ctl_s CTL_RST = '{st: ST_IDLE, sck_oe_n: 1'h1, dat_oe_n: 1'h1,
                               mosi_oe_n: 1'h1, req_n: 1'h1, default: '0};

endpackage

// ---- pkg/shift_if.sv ----
/*
  Carrier between the port controller and its byte shifter.
  Assumes both ends sit in the same core clock domain.
*/
`timescale 1ns/1ps
interface shift_if;
  logic                                load;
  logic [serial_host_pkg::BYTE_W-1:0]  load_data;
  logic                                shift;
  logic                                bit_in;
  logic                                msb;
  logic [serial_host_pkg::BYTE_W-1:0]  data;
  logic [serial_host_pkg::CNT_W-1:0]   count;

  modport ctrl (output load, load_data, shift, bit_in, input msb, data, count);
  modport unit (input load, load_data, shift, bit_in, output msb, data, count);
endinterface

// ---- testbench/spi_slave_model.sv ----
/*
  SPI slave model on the far side of the port, mode 0 only.
  Assumes the line idles high, as with a pull-up, while disabled.
*/
`timescale 1ns/1ps
module spi_slave_model (
  // Pins and setup
  input  wire logic       en_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] data_i,
  output logic            miso_o,
  output logic [7:0]      got_o
);
  logic [7:0] sr;
  // Load on enable, shift out on falling edge
  always @(posedge en_i) sr = data_i;
  always @(negedge sck_i) if (en_i) sr = sr << 1;
  // Sample master data on rising edge
  always @(posedge sck_i) if (en_i) got_o = {got_o[6:0], mosi_i};
  // Released line shows the pull-up level
  assign miso_o = en_i ? sr[7] : 1'b1;
endmodule // spi_slave_model

// ---- testbench/tb.sv ----
/*
  Self-checking bench for the serial host port.
  Assumes the SPI slave model and pull-ups on the shared lines.
*/
`timescale 1ns/1ps
module tb;
  logic clock_i = 0, rst_n_i = 0, port_rst, i2c, mst, tx_start, ext_sck, ext_mosi, ss_n, en;
  logic rx_valid, busy, berr, aerr, sdet, pdet, sck_o, sck_oe_n, sda_o, sda_oe_n, s, p, h;
  logic mosi_o, mosi_oe_n, part_miso, ext_sda, cpha, take, req_n;
  logic [7:0] tx, pdata, rx_data, got, sg;
  int bad_count = 0, checks = 0, i, n;
  // Pin levels from all drivers
  wire sck = sck_oe_n ? ext_sck : sck_o;
  wire sda = sda_oe_n ? part_miso & ext_sda : sda_o;
  // Low address strap reads low in I2C mode
  wire mosi = mosi_oe_n ? ext_mosi & !i2c : mosi_o;
  always #50 clock_i = ~clock_i;
  serial_host_port dut (
    .clk_i(clock_i), .rst_n_i(rst_n_i), .port_rst_i(port_rst), .i2c_mode_i(i2c),
    .master_i(mst), .cpol_i(1'b0), .cpha_i(cpha), .addr_mid_i(1'b0), .tx_data_i(tx),
    .tx_start_i(tx_start), .rx_taken_i(take), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .busy_o(busy), .bus_error_o(berr), .ack_error_o(aerr), .start_det_o(sdet),
    .stop_det_o(pdet), .sck_scl_i(sck), .sck_scl_o(sck_o), .sck_scl_oe_n_o(sck_oe_n),
    .miso_sda_i(sda), .miso_sda_o(sda_o), .miso_sda_oe_n_o(sda_oe_n),
    .mosi_addr_low_i(mosi), .mosi_addr_low_o(mosi_o), .mosi_addr_low_oe_n_o(mosi_oe_n),
    .ss_n_addr_high_i(ss_n), .host_req_n_o(req_n));
  spi_slave_model partner (.en_i(en), .sck_i(sck), .mosi_i(mosi), .data_i(pdata),
    .miso_o(part_miso), .got_o(got));
  // Inputs change just after the edge
  task step(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for a received byte
  task wait_rx;
    for (n = 0; n < 200 && rx_valid !== 1; n++) step(1);
    if (rx_valid !== 1)
    begin
      bad_count++;
      complete_run;
    end
  endtask
  task start_tx;
    step(3);
    tx_start = 1;
    step(1);
    tx_start = 0;
  endtask
  task t_master;
    {mst, pdata, tx, en} = {1'b1, 8'h3c, 8'ha5, 1'b1};
    start_tx;
    step(2);
    cmp(sck_oe_n, 0);
    wait_rx;
    cmp(rx_data, 8'h3c);
    cmp(got, 8'ha5);
    cmp(req_n, 0);
    take = 1;
    step(1);
    take = 0;
    cmp(req_n, 1);
    $display("spi master done");
  endtask
  task t_berr;
    start_tx;
    step(20);
    ss_n = 0;
    step(4);
    cmp(berr, 1);
    port_rst = 1;
    step(1);
    cmp({sck_oe_n, sda_oe_n, mosi_oe_n}, 3'h7);
    cmp({berr, busy}, 0);
    {port_rst, ss_n, en} = 3'b010;
    $display("bus error done");
  endtask
  // One slave byte clocked by the bench
  task sbyte(input logic [7:0] b);
    for (i = 7; i >= 0; i--)
    begin
      {ext_mosi, ext_sda} = {2{b[i]}};
      step(4);
      ext_sck = 1;
      step(4);
      sg = {sg[6:0], sda};
      ext_sck = 0;
      step(1);
    end
  endtask
  // Start or repeated start, then clock low
  task i2c_go;
    ext_sda = 1;
    step(2);
    ext_sck = 1;
    step(4);
    ext_sda = 0;
    step(4);
    ext_sck = 0;
    step(2);
  endtask
  // Ninth clock with the bench releasing data
  task ack9(input logic e);
    ext_sda = 1;
    step(4);
    ext_sck = 1;
    step(4);
    cmp(sda, e);
    ext_sck = 0;
  endtask
  task t_i2c_slave;
    mst = 0;
    step(3);
    i2c_go;
    sbyte(8'h5a);
    ack9(1);
    i2c_go;
    sbyte(8'h58);
    ack9(0);
    sbyte(8'h69);
    ack9(0);
    cmp(rx_data, 8'h69);
    ext_sda = 0;
    step(2);
    ext_sck = 1;
    step(4);
    ext_sda = 1;
    step(6);
    cmp({busy, sda_oe_n, sck_oe_n}, 3'h3);
    $display("i2c slave done");
  endtask
  task t_slave;
    {mst, tx} = {1'b0, 8'h96};
    step(3);
    sbyte(8'hff);
    cmp(rx_data, 8'h00);
    cmp(sda_oe_n, 1);
    ss_n = 0;
    sbyte(8'h5a);
    step(4);
    cmp(rx_data, 8'h5a);
    cmp(sg, 8'h96);
    ss_n = 1;
    step(6);
    cmp(sda_oe_n, 1);
    cpha = 1;
    step(2);
    ss_n = 0;
    sbyte(8'hc3);
    step(4);
    cmp(rx_data, 8'hc3);
    cmp(sg, 8'h96);
    ss_n = 1;
    step(6);
    $display("spi slave done");
  endtask
  task t_i2c;
    {i2c, mst, ext_sck, ext_sda, tx, s, p, h} = {4'b1111, 8'ha4, 3'b000};
    start_tx;
    repeat (1110)
    begin
      {s, p, h} = {s | sdet, p | pdet, h | sck_o};
      step(1);
    end
    cmp({s, p}, 2'h3);
    cmp({h, sck_oe_n, busy}, 3'h2);
    cmp(aerr, 1);
    cmp(sda, 1);
    $display("i2c master done");
  endtask
  // Main sequence
  initial
  begin
    {port_rst, i2c, mst, tx_start, ext_sck, ext_mosi, en, ss_n, take, ext_sda, cpha} = 11'h00a;
    {tx, pdata} = 16'h0000;
    step(5);
    cmp({sck_oe_n, sda_oe_n, mosi_oe_n}, 3'h7);
    rst_n_i = 1;
    t_master;
    t_berr;
    t_slave;
    t_i2c;
    t_i2c_slave;
    complete_run;
  end
endmodule // tb

// ---- verilog/byte_shifter.sv ----
/*
  Eight-bit MSB-first shift register with a count of bits shifted since load.
  Assumes load and shift strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
module byte_shifter (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // Control side
  shift_if.unit      sh
);

  logic [serial_host_pkg::BYTE_W-1:0] data;
  logic [serial_host_pkg::BYTE_W-1:0] next_data;
  logic [serial_host_pkg::CNT_W-1:0]  count;
  logic [serial_host_pkg::CNT_W-1:0]  next_count;

  // Load wins over shift so a byte boundary can reload in one cycle
  always_comb
  begin
    next_data  = data;
    next_count = count;
    if (sh.load)
    begin
      next_data  = sh.load_data;
      next_count = '0;
    end
    else if (sh.shift)
    begin
      next_data  = {data[serial_host_pkg::BYTE_W-2:0], sh.bit_in};
      next_count = count + 4'h1;
    end
  end

  // Register stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data  <= '0;
      count <= '0;
    end
    else
    begin
      data  <= next_data;
      count <= next_count;
    end
  end

  // Views for the controller
  assign sh.msb   = data[serial_host_pkg::BYTE_W-1];
  assign sh.data  = data;
  assign sh.count = count;

endmodule // byte_shifter

// ---- verilog/serial_host_port.sv ----
/*
  Dual-mode serial host port: SPI master/slave or I2C master/slave on shared pins.
  Assumes a 10 MHz clock, pins sampled through two flops, configuration and
  user strobes synchronous to clk_i, and external pull-ups on the I2C lines.
*/
`timescale 1ns/1ps
// Functional notes
// - Four shared pins serve SPI or I2C
// - SPI clock driven as master, input as slave
// - Master SPI clock from own divider
// - Slave ignores clock while select deasserted
// - Change on one edge, sample on other
// - I2C clock open-drain master, input slave
// - Pins released during any port reset
// - SPI master samples data from slave line
// - Slave data out driven only when selected
// - I2C data input receiving, open-drain transmitting
// - I2C data stable while clock high
// - I2C data changes only while clock low
// - Idle bus has data line high
// - Data falling, clock high means start
// - Data rising, clock high means stop
// - Master sends on MOSI, slave receives
// - Select asserted as master flags bus error
// - Slave address uses address pins
module serial_host_port (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_n_i,
  // Configuration
  input  wire logic                                port_rst_i,
  input  wire logic                                i2c_mode_i,
  input  wire logic                                master_i,
  input  wire logic                                cpol_i,
  input  wire logic                                cpha_i,
  input  wire logic                                addr_mid_i,
  // User side
  input  wire logic [serial_host_pkg::BYTE_W-1:0]  tx_data_i,
  input  wire logic                                tx_start_i,
  input  wire logic                                rx_taken_i,
  output logic      [serial_host_pkg::BYTE_W-1:0]  rx_data_o,
  output logic                                     rx_valid_o,
  output logic                                     busy_o,
  output logic                                     bus_error_o,
  output logic                                     ack_error_o,
  output logic                                     start_det_o,
  output logic                                     stop_det_o,
  // Pins
  input  wire logic                                sck_scl_i,
  output logic                                     sck_scl_o,
  output logic                                     sck_scl_oe_n_o,
  input  wire logic                                miso_sda_i,
  output logic                                     miso_sda_o,
  output logic                                     miso_sda_oe_n_o,
  input  wire logic                                mosi_addr_low_i,
  output logic                                     mosi_addr_low_o,
  output logic                                     mosi_addr_low_oe_n_o,
  input  wire logic                                ss_n_addr_high_i,
  output logic                                     host_req_n_o
);

  logic [1:0]                         rst_pipe;
  logic                               rst_n;
  logic [serial_host_pkg::PIN_N-1:0]  pin_raw;
  logic [serial_host_pkg::PIN_N-1:0]  pin_meta;
  logic [serial_host_pkg::PIN_N-1:0]  pin_s;
  logic [serial_host_pkg::PIN_N-1:0]  pin_p;
  logic                               sck_s;
  logic                               sck_p;
  logic                               dat_s;
  logic                               dat_p;
  logic                               mosi_s;
  logic                               ss_act;
  logic                               lead;
  logic                               trail;
  logic                               samp;
  logic                               shft;
  logic                               scl_rise;
  logic                               scl_fall;
  logic                               i2c_start;
  logic                               i2c_stop;
  logic                               tick;
  logic [serial_host_pkg::TMR_W-1:0]  rld;
  logic [6:0]                         own_addr;
  logic                               addr_hit;
  serial_host_pkg::ctl_s              ctl;
  serial_host_pkg::ctl_s              next_ctl;

  shift_if sh ();

  byte_shifter u_shifter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .sh      (sh.unit)
  );

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'h1};
  end
  assign rst_n = rst_pipe[1];

  // Pin synchronisers; pin_meta feeds pin_s only, pin_p keeps one more for edges
  assign pin_raw = {ss_n_addr_high_i, mosi_addr_low_i, miso_sda_i, sck_scl_i};
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 4'hF;
      pin_s    <= 4'hF;
      pin_p    <= 4'hF;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
      pin_p    <= pin_s;
    end
  end

  // Decoded pin events
  assign sck_s  = pin_s[serial_host_pkg::PIN_SCK];
  assign sck_p  = pin_p[serial_host_pkg::PIN_SCK];
  assign dat_s  = pin_s[serial_host_pkg::PIN_DAT];
  assign dat_p  = pin_p[serial_host_pkg::PIN_DAT];
  assign mosi_s = pin_s[serial_host_pkg::PIN_MOSI];
  assign ss_act = !pin_s[serial_host_pkg::PIN_SS];
  assign lead   = ((sck_s ^ ctl.cpol) & !(sck_p ^ ctl.cpol)) & ss_act;
  assign trail  = (!(sck_s ^ ctl.cpol) & (sck_p ^ ctl.cpol)) & ss_act;
  assign samp   = ctl.cpha ? trail : lead;
  assign shft   = ctl.cpha ? lead : trail;
  assign scl_rise  = ctl.i2c & sck_s & !sck_p;
  assign scl_fall  = ctl.i2c & !sck_s & sck_p;
  assign i2c_start = ctl.i2c & sck_s & sck_p & dat_p & !dat_s;
  assign i2c_stop  = ctl.i2c & sck_s & sck_p & !dat_p & dat_s;
  assign tick      = (ctl.tmr == '0);
  assign rld       = ctl.i2c ? serial_host_pkg::SCL_QTR_RLD : serial_host_pkg::SCK_HALF_RLD;
  assign own_addr  = {serial_host_pkg::SLV_ADDR_TOP, !ss_act, addr_mid_i, mosi_s};
  assign addr_hit  = (sh.data[serial_host_pkg::BYTE_W-1:1] == own_addr) && !sh.data[0];

  // Port controller: next state, pin drives and user flags
  always_comb
  begin
    next_ctl           = ctl;
    next_ctl.rx_valid  = 1'h0;
    next_ctl.start_det = 1'h0;
    next_ctl.stop_det  = 1'h0;
    next_ctl.tmr       = tick ? rld : ctl.tmr - 5'h01;
    sh.load            = 1'h0;
    sh.load_data       = tx_data_i;
    sh.shift           = 1'h0;
    sh.bit_in          = 1'h0;
    if (rx_taken_i)
      next_ctl.req_n = 1'h1; // Later sets in this process win
    if (!ctl.i2c && ctl.master && ss_act)
      next_ctl.bus_err = 1'h1;
    if (i2c_start)
    begin
      next_ctl.start_det = 1'h1;
      next_ctl.busy_bus  = 1'h1;
    end
    if (i2c_stop)
    begin
      next_ctl.stop_det = 1'h1;
      next_ctl.busy_bus = 1'h0;
    end
    case (ctl.st)
      serial_host_pkg::ST_IDLE:
      begin
        // Configuration latched only here; directions use the latched copy
        next_ctl.i2c       = i2c_mode_i;
        next_ctl.master    = master_i;
        next_ctl.cpol      = cpol_i;
        next_ctl.cpha      = cpha_i;
        next_ctl.busy      = 1'h0;
        next_ctl.ph        = serial_host_pkg::PH_0;
        next_ctl.edges     = '0;
        next_ctl.tmr       = rld;
        next_ctl.dat_o     = 1'h0;
        next_ctl.dat_oe_n  = 1'h1;
        next_ctl.sck_o     = ctl.cpol & !ctl.i2c;
        next_ctl.sck_oe_n  = ctl.i2c | !ctl.master;
        next_ctl.mosi_o    = 1'h0;
        next_ctl.mosi_oe_n = ctl.i2c | !ctl.master;
        sh.load            = 1'h1;
        if (ctl.i2c && !ctl.master && i2c_start)
        begin
          next_ctl.st      = serial_host_pkg::ST_I2C_SLV;
          // Role kept as decided here, not as the inputs read now
          next_ctl.i2c     = 1'h1;
          next_ctl.master  = 1'h0;
          next_ctl.first   = 1'h1;
          next_ctl.match   = 1'h0;
          next_ctl.slv_ack = 1'h0;
          next_ctl.busy    = 1'h1;
        end
        else if (!ctl.i2c && !ctl.master && ss_act)
        begin
          next_ctl.st       = serial_host_pkg::ST_SPI;
          next_ctl.i2c      = 1'h0;
          next_ctl.master   = 1'h0;
          next_ctl.busy     = 1'h1;
          next_ctl.dat_o    = tx_data_i[serial_host_pkg::BYTE_W-1];
          next_ctl.dat_oe_n = 1'h0;
        end
        else if (tx_start_i && ctl.master && (!ctl.i2c || (!ctl.busy_bus && dat_s && sck_s)))
        begin
          next_ctl.st     = ctl.i2c ? serial_host_pkg::ST_I2C_START : serial_host_pkg::ST_SPI;
          next_ctl.i2c    = ctl.i2c;
          next_ctl.master = 1'h1;
          next_ctl.busy   = 1'h1;
          next_ctl.mosi_o = tx_data_i[serial_host_pkg::BYTE_W-1];
        end
      end
      serial_host_pkg::ST_SPI:
      begin
        if (ctl.master)
        begin
          if (tick && ctl.edges == serial_host_pkg::SPI_EDGES)
          begin
            next_ctl.st       = serial_host_pkg::ST_IDLE;
            next_ctl.rx       = sh.data;
            next_ctl.rx_valid = 1'h1;
            next_ctl.req_n    = 1'h0;
          end
          else if (tick)
          begin
            next_ctl.sck_o = !ctl.sck_o;
            next_ctl.edges = ctl.edges + 5'h01;
            if ((ctl.sck_o == ctl.cpol) != ctl.cpha)
            begin
              sh.shift  = 1'h1;
              sh.bit_in = dat_s;
            end
            else
              next_ctl.mosi_o = sh.msb;
          end
        end
        else if (!ss_act)
        begin
          next_ctl.st       = serial_host_pkg::ST_IDLE;
          next_ctl.dat_oe_n = 1'h1;
        end
        else if (samp)
        begin
          sh.shift  = 1'h1;
          sh.bit_in = mosi_s;
          if (sh.count == serial_host_pkg::LAST_BIT)
          begin
            sh.load           = 1'h1; // Next byte ready for a continued frame
            next_ctl.rx       = {sh.data[serial_host_pkg::BYTE_W-2:0], mosi_s};
            next_ctl.rx_valid = 1'h1;
            next_ctl.req_n    = 1'h0;
          end
        end
        else if (shft)
          next_ctl.dat_o = sh.msb;
      end
      serial_host_pkg::ST_I2C_START:
      begin
        if (tick)
        begin
          next_ctl.ph = ctl.ph + 2'h1;
          case (ctl.ph)
            serial_host_pkg::PH_0: next_ctl.dat_oe_n = 1'h0;
            serial_host_pkg::PH_1: next_ctl.sck_oe_n = 1'h0;
            serial_host_pkg::PH_3:
            begin
              next_ctl.st       = serial_host_pkg::ST_I2C_BIT;
              next_ctl.dat_oe_n = sh.msb;
            end
            default: ;
          endcase
        end
      end
      serial_host_pkg::ST_I2C_BIT:
      begin
        // Clock stretching is not honoured; far slaves must keep up
        if (tick)
        begin
          next_ctl.ph = ctl.ph + 2'h1;
          case (ctl.ph)
            serial_host_pkg::PH_0: next_ctl.sck_oe_n = 1'h1;
            serial_host_pkg::PH_2:
            begin
              next_ctl.sck_oe_n = 1'h0;
              sh.shift          = 1'h1;
              sh.bit_in         = dat_s;
            end
            serial_host_pkg::PH_3:
            begin
              next_ctl.dat_oe_n = sh.msb;
              if (sh.count == serial_host_pkg::BYTE_CNT)
              begin
                next_ctl.st       = serial_host_pkg::ST_I2C_ACK;
                next_ctl.dat_oe_n = 1'h1;
              end
            end
            default: ;
          endcase
        end
      end
      serial_host_pkg::ST_I2C_ACK:
      begin
        if (tick)
        begin
          next_ctl.ph = ctl.ph + 2'h1;
          case (ctl.ph)
            serial_host_pkg::PH_0: next_ctl.sck_oe_n = 1'h1;
            serial_host_pkg::PH_1: next_ctl.ack_err = dat_s;
            serial_host_pkg::PH_2: next_ctl.sck_oe_n = 1'h0;
            default:
            begin
              next_ctl.st       = serial_host_pkg::ST_I2C_STOP;
              next_ctl.dat_oe_n = 1'h0;
            end
          endcase
        end
      end
      serial_host_pkg::ST_I2C_STOP:
      begin
        if (tick)
        begin
          next_ctl.ph = ctl.ph + 2'h1;
          case (ctl.ph)
            serial_host_pkg::PH_0: next_ctl.sck_oe_n = 1'h1;
            serial_host_pkg::PH_1: next_ctl.dat_oe_n = 1'h1;
            serial_host_pkg::PH_3: next_ctl.st = serial_host_pkg::ST_IDLE;
            default: ;
          endcase
        end
      end
      serial_host_pkg::ST_I2C_SLV:
      begin
        if (i2c_stop)
        begin
          next_ctl.st       = serial_host_pkg::ST_IDLE;
          next_ctl.dat_oe_n = 1'h1;
        end
        else if (i2c_start)
        begin
          sh.load           = 1'h1; // Repeated start restarts the address byte
          next_ctl.first    = 1'h1;
          next_ctl.match    = 1'h0;
          next_ctl.slv_ack  = 1'h0;
          next_ctl.dat_oe_n = 1'h1;
        end
        else if (scl_rise && !ctl.slv_ack)
        begin
          sh.shift  = 1'h1;
          sh.bit_in = dat_s;
        end
        else if (scl_fall)
        begin
          next_ctl.dat_oe_n = 1'h1;
          next_ctl.slv_ack  = 1'h0;
          if (!ctl.slv_ack && sh.count == serial_host_pkg::BYTE_CNT)
          begin
            sh.load        = 1'h1;
            next_ctl.first = 1'h0;
            if (ctl.first)
            begin
              next_ctl.match    = addr_hit;
              next_ctl.dat_oe_n = !addr_hit;
              next_ctl.slv_ack  = addr_hit;
            end
            else if (ctl.match)
            begin
              next_ctl.rx       = sh.data;
              next_ctl.rx_valid = 1'h1;
              next_ctl.req_n    = 1'h0;
              next_ctl.dat_oe_n = 1'h0;
              next_ctl.slv_ack  = 1'h1;
            end
          end
        end
      end
      default: next_ctl.st = serial_host_pkg::ST_IDLE;
    endcase
    if (port_rst_i)
      next_ctl = serial_host_pkg::CTL_RST;
  end

  // Control register
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ctl <= serial_host_pkg::CTL_RST;
    else
      ctl <= next_ctl;
  end

  // Outputs, each straight from the control register
  assign sck_scl_o            = ctl.sck_o;
  assign sck_scl_oe_n_o       = ctl.sck_oe_n;
  assign miso_sda_o           = ctl.dat_o;
  assign miso_sda_oe_n_o      = ctl.dat_oe_n;
  assign mosi_addr_low_o      = ctl.mosi_o;
  assign mosi_addr_low_oe_n_o = ctl.mosi_oe_n;
  assign host_req_n_o         = ctl.req_n;
  assign rx_data_o            = ctl.rx;
  assign rx_valid_o           = ctl.rx_valid;
  assign busy_o               = ctl.busy;
  assign bus_error_o          = ctl.bus_err;
  assign ack_error_o          = ctl.ack_err;
  assign start_det_o          = ctl.start_det;
  assign stop_det_o           = ctl.stop_det;

  // Checks on the pin drives, event flags and slave shifting
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  port_tri_a: assert property (port_rst_i |=> sck_scl_oe_n_o && miso_sda_oe_n_o
      && mosi_addr_low_oe_n_o)
    else $error("pins not released after port reset");
  sck_dir_a: assert property (!ctl.i2c && !ctl.master |=> sck_scl_oe_n_o)
    else $error("spi slave drives clock pin");
  scl_od_a: assert property (ctl.i2c |=> !sck_scl_o)
    else $error("i2c clock driven high");
  miso_hiz_a: assert property (!ctl.i2c && !ctl.master && !ss_act |=> miso_sda_oe_n_o)
    else $error("slave data out driven while deselected");
  bus_err_a: assert property (!ctl.i2c && ctl.master && ss_act && !port_rst_i
      |=> bus_error_o ##1 bus_error_o || $past(port_rst_i))
    else $error("select as master not flagged");
  sda_hold_a: assert property (ctl.st inside {serial_host_pkg::ST_I2C_BIT,
      serial_host_pkg::ST_I2C_ACK} && $changed(miso_sda_oe_n_o)
      |-> !sck_scl_oe_n_o && !$past(sck_scl_oe_n_o))
    else $error("data changed while clock released");
  sda_change_a: assert property (ctl.i2c && ctl.master && !$past(port_rst_i)
      && $changed(miso_sda_oe_n_o) && sck_scl_oe_n_o && $past(sck_scl_oe_n_o)
      |-> ctl.st inside {serial_host_pkg::ST_I2C_START, serial_host_pkg::ST_I2C_STOP})
    else $error("data moved under high clock outside start or stop");
  start_det_a: assert property (ctl.i2c && sck_s && sck_p && dat_p && !dat_s
      && !port_rst_i |=> start_det_o)
    else $error("start event missed");
  stop_det_a: assert property (ctl.i2c && sck_s && sck_p && !dat_p && dat_s
      && !port_rst_i |=> stop_det_o)
    else $error("stop event missed");
  spi_ignore_a: assert property (!ctl.i2c && !ctl.master && !ss_act
      |=> sh.count == $past(sh.count) || $past(ctl.st) == serial_host_pkg::ST_IDLE)
    else $error("slave shifted while deselected");

endmodule // serial_host_port
